// ==== design/dual_timer_counter_capture.v ====
// two 8-bit timer/counters, cascadable, with capture and compare output
// Summary of operation
// - timer counts up, clears on match, flags
// - first timer prescale 2 to 1024
// - second timer prescale 1, 2 or 8
// - first timer counts event pin rising edges
// - first timer read shows capture or count
// - second timer count/capture read, match separate
// - cascaded counters match pair, first flag
// - mode bits decode into operating modes
// - each timer has own capture enable
// - edge copies count, clears, restarts counter
// - edge select rise/fall/both, edge flags
// - match flag still raised in capture
// - cascaded capture uses 16-bit pair
// - compare match toggles shared output pin
//
// Chosen here: the placing of the registers and the APB register port.
`default_nettype none
`include "tc_defs.vh"

module dual_timer_counter_capture #(
  parameter PRE_W = 10
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        srst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // external pins
  input  wire        event_input_pin_i,
  input  wire [1:0]  capture_edge_pin_i,
  // interrupt acknowledge and flags
  input  wire [3:0]  irq_ack_i,
  output reg  [3:0]  timer_irq_flag_o,
  // compare output pin
  output reg         compare_output_pin_o,
  output reg         compare_output_oe_o
);

  // software registers
  reg [4:0]       first_timer_mode_reg_r;
  reg [5:0]       second_timer_mode_reg_r;
  reg [7:0]       first_match_value_r;
  reg [7:0]       second_match_value_r;
  reg [7:0]       pulse_period_low_r;
  reg [7:0]       pulse_duty_low_r;
  reg [3:0]       pulse_high_bits_r;
  reg [1:0]       port_function_reg_r;
  reg [3:0]       edge_select_reg_r;
  reg [7:0]       port0_direction_reg_r;
  // counting state
  reg [PRE_W-1:0] pre_r;
  reg [7:0]       first_counter_r;
  reg [7:0]       second_counter_r;
  reg [7:0]       first_capture_value_r;
  reg [7:0]       second_capture_value_r;
  reg [3:0]       flag_nxt;
  reg [31:0]      rd_nxt;
  reg             err_nxt;

  // divided clock tick for a first-timer style select code
  function div_tick;
    input [2:0]       code;
    input [PRE_W-1:0] p;
    begin
      case (code)
        `FIRST_CLOCK_SELECT_D2:    div_tick = &p[0];
        `FIRST_CLOCK_SELECT_D4:    div_tick = &p[1:0];
        `FIRST_CLOCK_SELECT_D8:    div_tick = &p[2:0];
        `FIRST_CLOCK_SELECT_D32:   div_tick = &p[4:0];
        `FIRST_CLOCK_SELECT_D128:  div_tick = &p[6:0];
        `FIRST_CLOCK_SELECT_D512:  div_tick = &p[8:0];
        `FIRST_CLOCK_SELECT_D1024: div_tick = &p[9:0];
        default:     div_tick = 1'b0;
      endcase
    end
  endfunction

  // does a rise/fall pair qualify under an edge select code
  function edge_hit;
    input [1:0] sel;
    input       rise;
    input       fall;
    begin
      case (sel)
        `EDGE_FALL: edge_hit = fall;
        `EDGE_RISE: edge_hit = rise;
        `EDGE_BOTH: edge_hit = rise | fall;
        default:    edge_hit = 1'b0;
      endcase
    end
  endfunction

  // pin synchronisers: 0 event, 1 capture pin 0, 2 capture pin 1
  wire [2:0] pin_w = {capture_edge_pin_i, event_input_pin_i};
  wire [2:0] rise_w;
  wire [2:0] fall_w;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      edge_sync u_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .pin_i  (pin_w[gi]),
        .rise_o (rise_w[gi]),
        .fall_o (fall_w[gi])
      );
    end
  endgenerate

  // mode decode
  wire [2:0] first_clock_select  = first_timer_mode_reg_r[`M0_CK_HI:0];
  wire [1:0] second_clock_select = second_timer_mode_reg_r[`M1_CK_HI:0];
  wire       first_capture_enable  = first_timer_mode_reg_r[`M0_CAP];
  wire       second_capture_enable = second_timer_mode_reg_r[`M1_CAP];
  wire       cascade_enable    = second_timer_mode_reg_r[`M1_CASC];
  wire       pulse_mod_enable  = second_timer_mode_reg_r[`M1_PWM];
  wire       compare_pin_select = port_function_reg_r[`PF_CMP];
  wire       run0 = first_timer_mode_reg_r[`M0_RUN];
  wire       run1 = second_timer_mode_reg_r[`M1_RUN];
  wire       evt_en = port_function_reg_r[`PF_EVT] &
                      ~port0_direction_reg_r[`DIR_EVT];

  // first timer clock: prescaler or event pin rising edge
  wire t0_tick = run0 & ((first_clock_select == `FIRST_CLOCK_SELECT_EXT) ?
                 (rise_w[0] & evt_en) :
                 div_tick(first_clock_select, pre_r));

  // second timer clock; code 11 gives no own tick, and cascade (M1_CASC) gates the tick off
  reg t1_div;
  always @* begin
    case (second_clock_select)
      `SECOND_CLOCK_SELECT_D1: t1_div = 1'b1;
      `SECOND_CLOCK_SELECT_D2: t1_div = div_tick(`FIRST_CLOCK_SELECT_D2, pre_r);
      `SECOND_CLOCK_SELECT_D8: t1_div = div_tick(`FIRST_CLOCK_SELECT_D8, pre_r);
      default:  t1_div = 1'b0;
    endcase
  end
  wire t1_tick = run1 & ~cascade_enable & t1_div;

  // cascaded view of the pair
  wire [15:0] cnt16 = {second_counter_r, first_counter_r};
  wire [15:0] inc16 = cnt16 + 16'h0001;
  wire [15:0] mat16 = {second_match_value_r, first_match_value_r};

  // capture edges; in cascade only capture pin 0 is used
  // capture needs run: a parked counter has nothing to give
  wire first_capture_enable_hit = run0 & first_capture_enable &
                  edge_hit(edge_select_reg_r[1:0], rise_w[1], fall_w[1]);
  wire second_capture_enable_hit = run1 & ~cascade_enable & second_capture_enable &
                  edge_hit(edge_select_reg_r[3:2], rise_w[2], fall_w[2]);

  // matches; cascade match raises only the first timer flag
  wire m0_hit = t0_tick & (cascade_enable ? (cnt16 == mat16) :
                (first_counter_r == first_match_value_r));
  // no second match in cascade: its tick is gated off there
  wire m1_hit = t1_tick & (second_counter_r == second_match_value_r);

  // prescaler free runs, shared by both timers
  // one divider for both keeps their ticks phase aligned
  always @(posedge clk_i) begin
    if (srst_i)
      pre_r <= {PRE_W{1'b0}};
    else
      pre_r <= pre_r + 1'b1;
  end

  // counters and capture registers
  // run low parks a counter at zero so a restart counts from zero
  always @(posedge clk_i) begin
    if (srst_i) begin
      first_counter_r        <= `BYTE_ZERO;
      second_counter_r       <= `BYTE_ZERO;
      first_capture_value_r  <= `BYTE_ZERO;
      second_capture_value_r <= `BYTE_ZERO;
    end else if (cascade_enable) begin
      if (!run0) begin
        first_counter_r  <= `BYTE_ZERO;
        second_counter_r <= `BYTE_ZERO;
      end else if (first_capture_enable_hit) begin
        first_capture_value_r  <= first_counter_r;
        second_capture_value_r <= second_counter_r;
        first_counter_r  <= `BYTE_ZERO;
        second_counter_r <= `BYTE_ZERO;
      end else if (m0_hit) begin
        first_counter_r  <= `BYTE_ZERO;
        second_counter_r <= `BYTE_ZERO;
      end else if (t0_tick) begin
        first_counter_r  <= inc16[7:0];
        second_counter_r <= inc16[15:8];
      end
    end else begin
      // capture wins over match and tick in the same cycle
      if (!run0)
        first_counter_r <= `BYTE_ZERO;
      else if (first_capture_enable_hit) begin
        first_capture_value_r <= first_counter_r;
        first_counter_r <= `BYTE_ZERO;
      end else if (m0_hit)
        first_counter_r <= `BYTE_ZERO;
      else if (t0_tick)
        first_counter_r <= first_counter_r + 1'b1;
      if (!run1)
        second_counter_r <= `BYTE_ZERO;
      else if (second_capture_enable_hit) begin
        second_capture_value_r <= second_counter_r;
        second_counter_r <= `BYTE_ZERO;
      end else if (m1_hit)
        second_counter_r <= `BYTE_ZERO;
      else if (t1_tick)
        second_counter_r <= second_counter_r + 1'b1;
    end
  end

  // apb phases
  wire setup  = psel_i & ~penable_i;
  wire access = psel_i & penable_i & pready_o;
  wire wr     = access & pwrite_i;

  // sticky flags: a set in the clearing cycle wins
  wire [3:0] sw_clr = (wr && paddr_i == `OFS_IRQ) ? pwdata_i[3:0] : 4'h0;
  always @* begin
    flag_nxt = timer_irq_flag_o & ~(sw_clr | irq_ack_i);
    flag_nxt[`IRQ_M0] = flag_nxt[`IRQ_M0] | m0_hit;
    flag_nxt[`IRQ_M1] = flag_nxt[`IRQ_M1] | m1_hit;
    flag_nxt[`IRQ_C0] = flag_nxt[`IRQ_C0] | first_capture_enable_hit;
    flag_nxt[`IRQ_C1] = flag_nxt[`IRQ_C1] | second_capture_enable_hit;
  end

  always @(posedge clk_i) begin
    if (srst_i)
      timer_irq_flag_o <= `NIB_ZERO;
    else
      timer_irq_flag_o <= flag_nxt;
  end

  // compare output: cascade match, or second timer match in 8-bit mode
  // pin parks low while off so each enable starts from a known level
  wire cmp_en  = compare_pin_select & ~pulse_mod_enable;
  wire cmp_evt = cascade_enable ? m0_hit : m1_hit;
  always @(posedge clk_i) begin
    if (srst_i) begin
      compare_output_pin_o <= 1'b0;
      compare_output_oe_o  <= 1'b0;
    end else begin
      compare_output_oe_o <= cmp_en;
      if (!cmp_en)
        compare_output_pin_o <= 1'b0;
      else if (cmp_evt)
        compare_output_pin_o <= ~compare_output_pin_o;
    end
  end

  // read mux; shared count/capture addresses follow the capture bits
  // counts are live, so a read may land either side of a tick
  always @* begin
    rd_nxt  = `WORD_ZERO;
    err_nxt = 1'b0;
    case (paddr_i)
      `OFS_MODE0:    rd_nxt[4:0] = first_timer_mode_reg_r;
      `OFS_MODE1:    rd_nxt[5:0] = second_timer_mode_reg_r;
      `OFS_T0_DATA:  rd_nxt[7:0] = first_capture_enable ?
                                   first_capture_value_r :
                                   first_counter_r;
      `OFS_T1_COUNT: rd_nxt[7:0] =
                       (second_capture_enable |
                        (cascade_enable & first_capture_enable)) ?
                       second_capture_value_r :
                       second_counter_r;
      `OFS_T1_MATCH: rd_nxt[7:0] = second_match_value_r;
      `OFS_PER_LOW:  rd_nxt[7:0] = pulse_period_low_r;
      `OFS_DUTY_LOW: rd_nxt[7:0] = pulse_duty_low_r;
      `OFS_PHIGH:    rd_nxt[3:0] = pulse_high_bits_r;
      `OFS_PORTFN:   rd_nxt[1:0] = port_function_reg_r;
      `OFS_EDGESEL:  rd_nxt[3:0] = edge_select_reg_r;
      `OFS_IRQ:      rd_nxt[3:0] = timer_irq_flag_o;
      `OFS_DIR0:     rd_nxt[7:0] = port0_direction_reg_r;
      default:       err_nxt     = 1'b1;
    endcase
  end

  // zero wait state slave: ready in the first access cycle
  // prdata reloads only on a read setup and holds between reads
  always @(posedge clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= `WORD_ZERO;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & err_nxt;
      if (setup && !pwrite_i)
        prdata_o <= rd_nxt;
    end
  end

  // register writes take effect at the access edge only
  // unmapped and read-only offsets fall through untouched
  always @(posedge clk_i) begin
    if (srst_i) begin
      first_timer_mode_reg_r  <= `MODE0_RST;
      second_timer_mode_reg_r <= `MODE1_RST;
      first_match_value_r     <= `MATCH_RST;
      second_match_value_r    <= `MATCH_RST;
      pulse_period_low_r      <= `MATCH_RST;
      pulse_duty_low_r        <= `BYTE_ZERO;
      pulse_high_bits_r       <= `NIB_ZERO;
      port_function_reg_r     <= `PAIR_ZERO;
      edge_select_reg_r       <= `NIB_ZERO;
      port0_direction_reg_r   <= `BYTE_ZERO;
    end else if (wr) begin
      case (paddr_i)
        `OFS_MODE0:    first_timer_mode_reg_r  <= pwdata_i[4:0];
        `OFS_MODE1:    second_timer_mode_reg_r <= pwdata_i[5:0];
        `OFS_T0_DATA:  first_match_value_r     <= pwdata_i[7:0];
        `OFS_T1_MATCH: second_match_value_r    <= pwdata_i[7:0];
        `OFS_PER_LOW:  pulse_period_low_r      <= pwdata_i[7:0];
        `OFS_DUTY_LOW: pulse_duty_low_r        <= pwdata_i[7:0];
        `OFS_PHIGH:    pulse_high_bits_r       <= pwdata_i[3:0];
        `OFS_PORTFN:   port_function_reg_r     <= pwdata_i[1:0];
        `OFS_EDGESEL:  edge_select_reg_r       <= pwdata_i[3:0];
        `OFS_DIR0:     port0_direction_reg_r   <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== design/edge_sync.v ====
// two-stage pin synchroniser with rising and falling edge pulses
`default_nettype none

module edge_sync (
  // clock and reset
  input  wire clk_i,
  input  wire srst_i,
  // pin and edge pulses
  input  wire pin_i,
  output reg  rise_o,
  output reg  fall_o
);

  reg meta_r;
  reg sync_r;
  reg prev_r;

  // meta_r feeds only sync_r
  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise_o <= sync_r & ~prev_r;
      fall_o <= ~sync_r & prev_r;
    end
  end

endmodule

`default_nettype wire

// ==== design/tc_defs.vh ====
// constants for the dual timer/counter with capture and compare output
`ifndef TC_DEFS_VH
`define TC_DEFS_VH

// register byte offsets on the APB bus
`define OFS_MODE0      8'h00
`define OFS_MODE1      8'h04
`define OFS_T0_DATA    8'h08
`define OFS_T1_COUNT   8'h0C
`define OFS_T1_MATCH   8'h10
`define OFS_PER_LOW    8'h14
`define OFS_DUTY_LOW   8'h18
`define OFS_PHIGH      8'h1C
`define OFS_PORTFN     8'h20
`define OFS_EDGESEL    8'h24
`define OFS_IRQ        8'h28
`define OFS_DIR0       8'h2C

// first_timer_mode_reg fields
`define M0_CK_HI       2
`define M0_CAP         3
`define M0_RUN         4
// second_timer_mode_reg fields
`define M1_CK_HI       1
`define M1_CAP         2
`define M1_CASC        3
`define M1_PWM         4
`define M1_RUN         5
// port_function_reg fields
`define PF_EVT         0
`define PF_CMP         1
// event pin direction bit in port0_direction_reg
`define DIR_EVT        3
// timer_irq_flag bit positions
`define IRQ_M0         0
`define IRQ_M1         1
`define IRQ_C0         2
`define IRQ_C1         3

// clock select codes
`define FIRST_CLOCK_SELECT_D2        3'h0
`define FIRST_CLOCK_SELECT_D4        3'h1
`define FIRST_CLOCK_SELECT_D8        3'h2
`define FIRST_CLOCK_SELECT_D32       3'h3
`define FIRST_CLOCK_SELECT_D128      3'h4
`define FIRST_CLOCK_SELECT_D512      3'h5
`define FIRST_CLOCK_SELECT_D1024     3'h6
`define FIRST_CLOCK_SELECT_EXT       3'h7
`define SECOND_CLOCK_SELECT_D1        2'h0
`define SECOND_CLOCK_SELECT_D2        2'h1
`define SECOND_CLOCK_SELECT_D8        2'h2

// capture edge codes per pin
`define EDGE_FALL      2'h1
`define EDGE_RISE      2'h2
`define EDGE_BOTH      2'h3

// reset values
`define MATCH_RST      8'hFF
`define BYTE_ZERO      8'h00
`define WORD_ZERO      32'h0000_0000
`define NIB_ZERO       4'h0
`define PAIR_ZERO      2'h0
`define MODE0_RST      5'h00
`define MODE1_RST      6'h00

`endif

// ==== testbench/dual_timer_counter_capture_chk.sv ====
// port-level assertions for the dual timer/counter block
`default_nettype none
module dual_timer_counter_capture_chk #(
  parameter PRE_W = 10
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        srst_i,
  // register bus
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // pins and flags
  input wire logic [1:0]  capture_edge_pin_i,
  input wire logic [3:0]  irq_ack_i,
  input wire logic [3:0]  timer_irq_flag_o,
  input wire logic        compare_output_pin_o,
  input wire logic        compare_output_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic       setup;
  logic       unmapped;
  logic       w1c;
  logic [3:0] keep;
  assign setup    = psel_i && !penable_i;
  assign unmapped = (paddr_i[1:0] != 2'h0) || (paddr_i > 8'h2C);
  assign w1c  = psel_i && penable_i && pready_o && pwrite_i
                && paddr_i == 8'h28;
  // bits neither acknowledged nor written off must survive
  assign keep = timer_irq_flag_o & ~irq_ack_i & ~(w1c ? pwdata_i[3:0] : 4'h0);

  rdy_after_setup_a: assert property (setup |=> pready_o)
    else $error("no ready after setup");
  rdy_cause_a: assert property (
    pready_o |-> psel_i && penable_i && $past(setup))
    else $error("ready without request");
  err_unmapped_a: assert property (
    setup |=> pslverr_o == $past(unmapped))
    else $error("error response wrong for address");
  err_with_rdy_a: assert property (pslverr_o |-> pready_o)
    else $error("error outside ready");
  flag_sticky_a: assert property (
    |keep |=> (timer_irq_flag_o & $past(keep)) == $past(keep))
    else $error("flag dropped without clear");
  first_capture_enable_sync_a: assert property (
    $rose(timer_irq_flag_o[2]) |->
      $past(capture_edge_pin_i[0], 2) != $past(capture_edge_pin_i[0], 6))
    else $error("pin0 flag without pin edge");
  second_capture_enable_sync_a: assert property (
    $rose(timer_irq_flag_o[3]) |->
      $past(capture_edge_pin_i[1], 2) != $past(capture_edge_pin_i[1], 6))
    else $error("pin1 flag without pin edge");
  pin_off_a: assert property (
    !compare_output_oe_o && !$past(compare_output_oe_o)
      |-> !compare_output_pin_o)
    else $error("compare pin high while off");
  reset_out_a: assert property (
    $fell(srst_i) |-> timer_irq_flag_o == 4'h0 && !pready_o
      && !compare_output_oe_o)
    else $error("outputs not cleared by reset");

  cover property (pslverr_o);
  cover property ($rose(timer_irq_flag_o[3]));
  cover property ($changed(compare_output_pin_o));
endmodule

bind dual_timer_counter_capture dual_timer_counter_capture_chk #(
  .PRE_W(PRE_W)
) chk (
  .clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .pslverr_o, .capture_edge_pin_i, .irq_ack_i,
  .timer_irq_flag_o, .compare_output_pin_o, .compare_output_oe_o
);
`default_nettype wire

// ==== testbench/dual_timer_counter_capture_tb.sv ====
// self-checking bench for the dual timer/counter block
`default_nettype none
`include "tc_defs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module dual_timer_counter_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i     = 1'b0;
  logic        srst_i    = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0000_0000;
  logic [3:0]  irq_ack_i = 4'h0;
  wire  [31:0] prdata_o;
  wire  [3:0]  timer_irq_flag_o;
  wire  [1:0]  capture_edge_pin_i;
  wire         pready_o, pslverr_o, event_input_pin_i;
  wire         compare_output_pin_o, compare_output_oe_o;
  int          n_errors = 0, checks_done = 0, cyc = 0;
  int          d0[7] = '{2, 4, 8, 32, 128, 512, 1024};
  int          d1[3] = '{1, 2, 8};

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  dual_timer_counter_capture DUT (
    .clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .event_input_pin_i,
    .capture_edge_pin_i, .irq_ack_i, .timer_irq_flag_o,
    .compare_output_pin_o, .compare_output_oe_o
  );
  pin_model pins (
    .clk_i, .evt_o(event_input_pin_i), .cap_o(capture_edge_pin_i)
  );

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // ready and data are read at the edge, before that edge updates them
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    r = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r)
  endtask
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (timer_irq_flag_o[b] !== 1'b1 && n < 5000);
    if (n >= 5000) n_errors++;
  endtask
  // cycles between two matches, and whether the compare pin flipped
  task automatic period(input int b, input int x, input logic tog);
    int   t0;
    logic p0;
    wait_flag(b);
    t0 = cyc;
    p0 = compare_output_pin_o;
    @(posedge clk_i);
    irq_ack_i <= 4'h1 << b;
    @(posedge clk_i);
    irq_ack_i <= 4'h0;
    wait_flag(b);
    `CHK("period", x, cyc - t0)
    `CHK("compare pin", p0 ^ tog, compare_output_pin_o)
  endtask
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    int          m, h, c;
    logic [31:0] q;
    void'($urandom(69873));
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    for (c = 0; c <= 8'h2C; c += 4)
      rd(8'(c), (c == 16 || c == 20) ? 32'hFF : 32'h0, "reset");
    apb(1'b0, 8'h30, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    wr(`OFS_T1_COUNT, 32'h5A);
    rd(`OFS_T1_COUNT, 32'h0, "read-only count");
    wr(`OFS_PORTFN, 32'h2);
    for (c = 0; c < 3; c++) begin
      m = 4 + $urandom % 37;
      wr(`OFS_MODE1, 32'h0);
      wr(`OFS_IRQ, 32'hF);
      wr(`OFS_T1_MATCH, m);
      wr(`OFS_MODE1, 32'h20 | c);
      period(1, (m + 1) * d1[c], 1'b1);
    end
    `CHK("compare enable", 1'b1, compare_output_oe_o)
    wr(`OFS_MODE1, 32'h0);
    for (c = 0; c < 7; c++) begin
      wr(`OFS_MODE0, 32'h0);
      wr(`OFS_IRQ, 32'hF);
      wr(`OFS_T0_DATA, 32'h2);
      wr(`OFS_MODE0, 32'h10 | c);
      period(0, 3 * d0[c], 1'b0);
    end
    wr(`OFS_MODE0, 32'h0);
    wr(`OFS_IRQ, 32'hF);
    wr(`OFS_T1_MATCH, 32'h1);
    wr(`OFS_T0_DATA, 32'h3);
    wr(`OFS_MODE1, 32'h0B);
    wr(`OFS_MODE0, 32'h10);
    period(0, (256 + 3 + 1) * 2, 1'b1);
    `CHK("second flag idle", 1'b0, timer_irq_flag_o[1])
    wr(`OFS_MODE0, 32'h0);
    wr(`OFS_MODE1, 32'h0);
    wr(`OFS_IRQ, 32'hF);
    wr(`OFS_PORTFN, 32'h1);
    wr(`OFS_DIR0, 32'h0);
    wr(`OFS_T0_DATA, 32'h5);
    wr(`OFS_MODE0, 32'h17);
    pins.evt_pulses(3, 3);
    repeat (8) @(posedge clk_i);
    rd(`OFS_T0_DATA, 32'h3, "event count");
    pins.evt_pulses(3, 2);
    repeat (8) @(posedge clk_i);
    rd(`OFS_T0_DATA, 32'h0, "event wrap");
    `CHK("event flag", 1'b1, timer_irq_flag_o[0])
    wr(`OFS_MODE0, 32'h0);
    wr(`OFS_T0_DATA, 32'hFF);
    wr(`OFS_T1_MATCH, 32'hFF);
    wr(`OFS_MODE1, 32'h24);
    wr(`OFS_MODE0, 32'h18);
    for (c = 1; c < 4; c++) begin
      h = 2 * (5 + $urandom % 20);
      wr(`OFS_EDGESEL, c | (c << 2));
      wr(`OFS_IRQ, 32'hF);
      fork
        pins.cap_toggles(0, h);
        pins.cap_toggles(1, h);
      join
      repeat (8) @(posedge clk_i);
      m = (c == 3) ? h : 2 * h;
      rd(`OFS_T1_COUNT, m - 1, "capture");
      apb(1'b0, `OFS_T0_DATA, 32'h0, r, e);
      `CHK("first capture", 1'b1, r == m / 2 - 1 || r == m / 2)
      `CHK("edge flags", 4'hC, timer_irq_flag_o & 4'hC)
    end
    // cascaded capture with a pair match below the pulse length
    wr(`OFS_MODE0, 32'h0);
    wr(`OFS_MODE1, 32'h0B);
    wr(`OFS_T1_MATCH, 32'h1);
    wr(`OFS_T0_DATA, 32'h3);
    wr(`OFS_EDGESEL, 32'h3);
    wr(`OFS_MODE0, 32'h18);
    h = 2 * (300 + $urandom % 100);
    fork
      pins.cap_toggles(0, h);
      begin
        repeat (3 * h + 8) @(posedge clk_i);
        irq_ack_i <= 4'h1;
        @(posedge clk_i);
        irq_ack_i <= 4'h0;
      end
    join
    repeat (8) @(posedge clk_i);
    apb(1'b0, `OFS_T0_DATA, 32'h0, r, e);
    apb(1'b0, `OFS_T1_COUNT, 32'h0, q, e);
    m = {q[7:0], r[7:0]} + 260;
    `CHK("wide capture", 1'b1, m == h / 2 || m == h / 2 - 1)
    `CHK("match in capture", 1'b1, timer_irq_flag_o[0])
    wr(`OFS_PORTFN, 32'h2);
    wr(`OFS_MODE1, 32'h10);
    repeat (2) @(posedge clk_i);
    `CHK("pulse mode compare", 1'b0, compare_output_oe_o)
    test_done();
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire

// ==== testbench/pin_model.sv ====
// external event and capture pin sources
`default_nettype none
module pin_model (
  // clock
  input  wire logic       clk_i,
  // pins
  output var  logic       evt_o,
  output var  logic [1:0] cap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    evt_o = 1'b0;
    cap_o = 2'h0;
  end
  // levels last whole cycles so the synchroniser cannot miss them
  task automatic evt_pulses(input int n, input int gap);
    repeat (n) begin
      @(posedge clk_i);
      evt_o <= 1'b1;
      repeat (gap) @(posedge clk_i);
      evt_o <= 1'b0;
      repeat (gap - 1) @(posedge clk_i);
    end
  endtask
  task automatic cap_toggles(input int k, input int h);
    repeat (4) begin
      repeat (h) @(posedge clk_i);
      cap_o[k] <= ~cap_o[k];
    end
  endtask
endmodule
`default_nettype wire
